// ---- design/bbp_dist_pwm.sv ----
// Distributed 256-pulse duty pattern generator
`timescale 1ns/1ps
module bbp_dist_pwm
  import bbp_pkg::*;
#(
  parameter int CNT_W = PULSE_W
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [7:0]       duty,
  input  wire logic [CNT_W-1:0] pulseLen,
  output logic                  patternOut
);

  logic [CNT_W-1:0] cycCnt_r;
  logic [7:0]       pulseIdx_r;
  logic [7:0]       modCount;
  logic             modPulse;
  logic             halfOn;

  // ==========================================================
  // Pulse and period counters
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cycCnt_r   <= '0;
      pulseIdx_r <= 8'h00;
    end else if (cycCnt_r >= pulseLen - CNT_W'(1)) begin
      cycCnt_r   <= '0;
      pulseIdx_r <= pulseIdx_r + 8'h01;
    end else begin
      cycCnt_r <= cycCnt_r + CNT_W'(1);
    end
  end

  // ==========================================================
  // Pulse shaping
  function automatic logic [7:0] bitRev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) bitRev[i] = v[7-i];
  endfunction

  always_comb begin
    modCount = duty[7] ? {duty[6:0], 1'b0} : 8'(9'h100 - {duty, 1'b0});
    modPulse = bitRev(pulseIdx_r) < modCount;
    halfOn   = cycCnt_r < (pulseLen >> 1);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) patternOut <= 1'b0;
    else if (duty == 8'h00) patternOut <= 1'b0;
    else if (modPulse) patternOut <= duty[7];
    else patternOut <= halfOn;
  end

endmodule // bbp_dist_pwm

// ---- design/bbp_drivers.sv ----
// Top of the white-LED boost, backlight PWM and low-frequency PWM drivers
`timescale 1ns/1ps
module bbp_drivers
  import bbp_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [7:0]   whiteDuty,
  input  wire logic         repetitionRateSelect,
  input  wire logic [7:0]   backlightDuty,
  input  wire logic         backlightRateSelect,
  input  wire bbpLfCfg_t    lfCfg,
  input  wire bbpAnaFlags_t anaFlags,
  output logic              powerSwitchOn,
  output logic              ledSwitchOn,
  output logic [1:0]        currentLimitSel,
  output bbpBoostState_t    boostState,
  output logic              backlightPwmOe,
  output logic              lowFreqPwmOe
);

  bbpAnaFlags_t     flagMeta_r;
  bbpAnaFlags_t     flagSync_r;
  bbpBoostState_t   stateNxt;
  logic [7:0]       softCnt_r;
  logic [6:0]       onCnt_r;
  logic             enable;
  logic             startPulse;
  logic             stopPulse;
  logic             whitePattern;
  logic [PULSE_W-1:0] whitePulseLen;
  logic [PULSE_W-1:0] bklPulseLen;

  // ==========================================================
  // Comparator synchronisers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flagMeta_r <= '0;
      flagSync_r <= '0;
    end else begin
      flagMeta_r <= anaFlags;
      flagSync_r <= flagMeta_r;
    end
  end

  // ==========================================================
  // Pattern generators
  always_comb begin
    whitePulseLen = repetitionRateSelect ? PULSE_FAST_CYC : PULSE_SLOW_CYC;
    bklPulseLen   = backlightRateSelect ? BKL_HI_CYC : BKL_LO_CYC;
  end

  bbp_dist_pwm #(
    .CNT_W (PULSE_W)
  ) u_whitePattern (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .duty       (whiteDuty),
    .pulseLen   (whitePulseLen),
    .patternOut (whitePattern)
  );

  // Same pattern engine drives the backlight pin
  bbp_dist_pwm #(
    .CNT_W (PULSE_W)
  ) u_backlightPattern (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .duty       (backlightDuty),
    .pulseLen   (bklPulseLen),
    .patternOut (backlightPwmOe)
  );

  bbp_lf_pwm u_lowFreqPwm (
    .ref_clk (ref_clk),
    .reset   (reset),
    .cfg     (lfCfg),
    .drainOe (lowFreqPwmOe)
  );

  // ==========================================================
  // Boost enable and switch-cycle conditions
  always_comb begin
    enable = (whiteDuty != 8'h00)
          && !flagSync_r.underVoltage && !flagSync_r.thermalShutdown;
    startPulse = (boostState != BST_OFF) && enable && !powerSwitchOn
              && flagSync_r.senseBelowRef && ledSwitchOn
              && !flagSync_r.overvoltage;
    stopPulse = flagSync_r.peakCurrentTrip || (onCnt_r == MAX_ON_CYC - 7'h01)
             || !ledSwitchOn || flagSync_r.overvoltage;
  end

  // ==========================================================
  // Boost sequencing
  always_comb begin
    stateNxt = boostState;
    if (!enable) begin
      stateNxt = BST_OFF;
    end else begin
      unique case (boostState)
        BST_OFF:   stateNxt = BST_SOFT1;
        BST_SOFT1: if (startPulse && softCnt_r == SOFT_STEP_LAST) stateNxt = BST_SOFT2;
        BST_SOFT2: if (startPulse && softCnt_r == SOFT_STEP_LAST) stateNxt = BST_RUN;
        BST_RUN:   stateNxt = BST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      boostState      <= BST_OFF;
      currentLimitSel <= LIM_125MA;
    end else begin
      boostState <= stateNxt;
      unique case (stateNxt)
        BST_SOFT2: currentLimitSel <= LIM_250MA;
        BST_RUN:   currentLimitSel <= LIM_500MA;
        default:   currentLimitSel <= LIM_125MA;
      endcase
    end
  end

  // Soft-start switch-cycle counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) softCnt_r <= 8'h00;
    else if (stateNxt != boostState) softCnt_r <= 8'h00;
    else if (startPulse) softCnt_r <= softCnt_r + 8'h01;
  end

  // ==========================================================
  // Switch drive
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) ledSwitchOn <= 1'b0;
    else ledSwitchOn <= enable && (boostState != BST_OFF) && whitePattern;
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      powerSwitchOn <= 1'b0;
    end else if (!enable || boostState == BST_OFF) begin
      powerSwitchOn <= 1'b0;
    end else if (powerSwitchOn) begin
      powerSwitchOn <= !stopPulse;
    end else begin
      powerSwitchOn <= startPulse;
    end
  end

  // On-time counter
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) onCnt_r <= 7'h00;
    else if (powerSwitchOn) onCnt_r <= onCnt_r + 7'h01;
    else onCnt_r <= 7'h00;
  end

  // ==========================================================
  // Checks
  sequence s_softStepEnd;
    startPulse && softCnt_r == SOFT_STEP_LAST && enable;
  endsequence

  sequence s_faultSeen;
    flagSync_r.underVoltage || flagSync_r.thermalShutdown;
  endsequence

  sequence s_switchDemand;
    boostState != BST_OFF && enable && !powerSwitchOn && ledSwitchOn
      && flagSync_r.senseBelowRef && !flagSync_r.overvoltage;
  endsequence

  property p_zeroOff;
    @(posedge ref_clk) disable iff (reset)
      whiteDuty == 8'h00 |=> boostState == BST_OFF && !ledSwitchOn && !powerSwitchOn;
  endproperty
  a_zeroOff: assert property (p_zeroOff) else $error("boost not off at zero duty");

  property p_enable;
    @(posedge ref_clk) disable iff (reset)
      boostState == BST_OFF && enable |=> boostState == BST_SOFT1;
  endproperty
  a_enable: assert property (p_enable) else $error("boost did not enter soft-start");

  property p_softLimit;
    @(posedge ref_clk) disable iff (reset)
      (boostState == BST_SOFT1 || boostState == BST_OFF) |-> currentLimitSel == LIM_125MA;
  endproperty
  a_softLimit: assert property (p_softLimit) else $error("wrong first limit");

  property p_softStep;
    @(posedge ref_clk) disable iff (reset)
      (boostState == BST_SOFT1) ##0 s_softStepEnd |=>
        boostState == BST_SOFT2 && currentLimitSel == LIM_250MA;
  endproperty
  a_softStep: assert property (p_softStep) else $error("soft-start step missed");

  property p_start;
    @(posedge ref_clk) disable iff (reset)
      $rose(powerSwitchOn) |-> $past(flagSync_r.senseBelowRef) && $past(ledSwitchOn);
  endproperty
  a_start: assert property (p_start) else $error("switch started without demand");

  property p_maxOn;
    @(posedge ref_clk) disable iff (reset)
      powerSwitchOn |-> onCnt_r < MAX_ON_CYC;
  endproperty
  a_maxOn: assert property (p_maxOn) else $error("on-time exceeded");

  property p_peakOff;
    @(posedge ref_clk) disable iff (reset)
      flagSync_r.peakCurrentTrip |=> !powerSwitchOn;
  endproperty
  a_peakOff: assert property (p_peakOff) else $error("switch on after peak trip");

  property p_ovpOff;
    @(posedge ref_clk) disable iff (reset)
      flagSync_r.overvoltage |=> !powerSwitchOn;
  endproperty
  a_ovpOff: assert property (p_ovpOff) else $error("switch on during overvoltage");

  property p_faultOff;
    @(posedge ref_clk) disable iff (reset)
      s_faultSeen |=> !powerSwitchOn && !ledSwitchOn && boostState == BST_OFF;
  endproperty
  a_faultOff: assert property (p_faultOff) else $error("switches not open on fault");

  property p_bklZero;
    @(posedge ref_clk) disable iff (reset)
      backlightDuty == 8'h00 |=> !backlightPwmOe;
  endproperty
  a_bklZero: assert property (p_bklZero) else $error("backlight on at zero duty");

  property p_lfOff;
    @(posedge ref_clk) disable iff (reset)
      !lfCfg.on |=> !lowFreqPwmOe;
  endproperty
  a_lfOff: assert property (p_lfOff) else $error("low-frequency output on while off");

  property p_pendingStart;
    @(posedge ref_clk) disable iff (reset)
      s_switchDemand |=> powerSwitchOn;
  endproperty
  a_pendingStart: assert property (p_pendingStart) else $error("start missed");

  property p_ledOffStop;
    @(posedge ref_clk) disable iff (reset)
      !ledSwitchOn |=> !powerSwitchOn;
  endproperty
  a_ledOffStop: assert property (p_ledOffStop) else $error("led open, switch on");

  property p_onLimitStop;
    @(posedge ref_clk) disable iff (reset)
      powerSwitchOn && onCnt_r == MAX_ON_CYC - 7'h01 |=> !powerSwitchOn;
  endproperty
  a_onLimitStop: assert property (p_onLimitStop) else $error("on-time not cut");

  property p_offOpen;
    @(posedge ref_clk) disable iff (reset)
      boostState == BST_OFF |-> !powerSwitchOn && !ledSwitchOn;
  endproperty
  a_offOpen: assert property (p_offOpen) else $error("switch closed while off");

  property p_ledFollow;
    @(posedge ref_clk) disable iff (reset)
      enable && boostState != BST_OFF |=> ledSwitchOn == $past(whitePattern);
  endproperty
  a_ledFollow: assert property (p_ledFollow) else $error("led switch off pattern");

  property p_softStep2;
    @(posedge ref_clk) disable iff (reset)
      (boostState == BST_SOFT2) ##0 s_softStepEnd |=>
        boostState == BST_RUN && currentLimitSel == LIM_500MA;
  endproperty
  a_softStep2: assert property (p_softStep2) else $error("second step missed");

  property p_soft2Limit;
    @(posedge ref_clk) disable iff (reset)
      boostState == BST_SOFT2 |-> currentLimitSel == LIM_250MA;
  endproperty
  a_soft2Limit: assert property (p_soft2Limit) else $error("wrong second limit");

  property p_runLimit;
    @(posedge ref_clk) disable iff (reset)
      boostState == BST_RUN |-> currentLimitSel == LIM_500MA;
  endproperty
  a_runLimit: assert property (p_runLimit) else $error("wrong running limit");

  property p_softCntClear;
    @(posedge ref_clk) disable iff (reset)
      stateNxt != boostState |=> softCnt_r == 8'h00;
  endproperty
  a_softCntClear: assert property (p_softCntClear) else $error("step count kept");

endmodule // bbp_drivers

// ---- design/bbp_lf_pwm.sv ----
// Low-frequency open-drain PWM with 16 duty slots
`timescale 1ns/1ps
module bbp_lf_pwm
  import bbp_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      reset,
  input  wire bbpLfCfg_t cfg,
  output logic           drainOe
);

  logic [LF_SLOT_W-1:0] slotCnt_r;
  logic [3:0]           slotIdx_r;

  // ==========================================================
  // Slot timing
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      slotCnt_r <= '0;
      slotIdx_r <= 4'h0;
    end else if (slotCnt_r >= lfSlotCycles(cfg.freqSel) - LF_SLOT_W'(1)) begin
      slotCnt_r <= '0;
      slotIdx_r <= slotIdx_r + 4'h1;
    end else begin
      slotCnt_r <= slotCnt_r + LF_SLOT_W'(1);
    end
  end

  // ==========================================================
  // Pull low for duty+1 slots of 16
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) drainOe <= 1'b0;
    else drainOe <= cfg.on && (slotIdx_r <= cfg.duty);
  end

endmodule // bbp_lf_pwm

// ---- design/bbp_pkg.sv ----
// Shared constants and types for the backlight, boost and PWM drivers
package bbp_pkg;

  // ==========================================================
  // Clock and pattern timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int PAT_PULSES     = 256;
  localparam int REP_FAST_HZ    = 183;
  localparam int REP_SLOW_HZ    = 122;
  localparam int BKL_RATE_LO_HZ = 15_625;
  localparam int BKL_RATE_HI_HZ = 23_400;
  localparam int PULSE_W        = 10;
  localparam logic [PULSE_W-1:0] PULSE_FAST_CYC = PULSE_W'(CLK_HZ / (REP_FAST_HZ * PAT_PULSES));
  localparam logic [PULSE_W-1:0] PULSE_SLOW_CYC = PULSE_W'(CLK_HZ / (REP_SLOW_HZ * PAT_PULSES));
  localparam logic [PULSE_W-1:0] BKL_LO_CYC     = PULSE_W'(CLK_HZ / BKL_RATE_LO_HZ);
  localparam logic [PULSE_W-1:0] BKL_HI_CYC     = PULSE_W'(CLK_HZ / BKL_RATE_HI_HZ);

  // ==========================================================
  // Boost timing and limits
  localparam int MAX_ON_NS = 6000;
  localparam logic [6:0] MAX_ON_CYC   = 7'(MAX_ON_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SOFT_STEP_LAST = 8'hFF;
  localparam logic [1:0] LIM_125MA   = 2'h0;
  localparam logic [1:0] LIM_250MA   = 2'h1;
  localparam logic [1:0] LIM_500MA   = 2'h2;
  localparam logic [7:0] DUTY_RESET  = 8'h00;

  // ==========================================================
  // Low-frequency PWM
  localparam int LF_SLOTS  = 16;
  localparam int LF_SLOT_W = 11;

  function automatic logic [LF_SLOT_W-1:0] lfSlotCycles(input logic [2:0] sel);
    int hz;
    unique case (sel)
      3'h0:    hz = 500;
      3'h1:    hz = 1000;
      3'h2:    hz = 1500;
      3'h3:    hz = 2000;
      3'h4:    hz = 3000;
      3'h5:    hz = 4500;
      3'h6:    hz = 7800;
      default: hz = 15600;
    endcase
    return LF_SLOT_W'(CLK_HZ / (hz * LF_SLOTS));
  endfunction

  // ==========================================================
  // Types
  typedef enum logic [1:0] {BST_OFF, BST_SOFT1, BST_SOFT2, BST_RUN} bbpBoostState_t;

  typedef struct packed {
    logic       on;
    logic [2:0] freqSel;
    logic [3:0] duty;
  } bbpLfCfg_t;

  typedef struct packed {
    logic overvoltage;
    logic underVoltage;
    logic thermalShutdown;
    logic peakCurrentTrip;
    logic senseBelowRef;
  } bbpAnaFlags_t;

endpackage

// ---- verification/bbp_drivers_bench.sv ----
// Self-checking bench for the boost, backlight and low-frequency PWM drivers
`timescale 1ns/1ps
module bbp_drivers_bench
  import bbp_pkg::*;
;
  logic           ref_clk, reset, repetitionRateSelect, backlightRateSelect;
  logic [7:0]     whiteDuty, backlightDuty;
  bbpLfCfg_t      lfCfg;
  bbpAnaFlags_t   anaFlags;
  logic           powerSwitchOn, ledSwitchOn, backlightPwmOe, lowFreqPwmOe;
  logic [1:0]     currentLimitSel;
  bbpBoostState_t boostState;
  logic [2:0]     faultCmd;
  logic           slowRamp, prevPs, prevLed;
  int             badCount, testsRun, startBase;
  int             starts = 0, maxRun = 0, runLen = 0, badStart = 0;
  int             lfHz [8] = '{500, 1000, 1500, 2000, 3000, 4500, 7800, 15600};

  bbp_drivers bbp_drivers_i (.ref_clk(ref_clk), .reset(reset), .whiteDuty(whiteDuty),
    .repetitionRateSelect(repetitionRateSelect), .backlightDuty(backlightDuty),
    .backlightRateSelect(backlightRateSelect), .lfCfg(lfCfg), .anaFlags(anaFlags),
    .powerSwitchOn(powerSwitchOn), .ledSwitchOn(ledSwitchOn),
    .currentLimitSel(currentLimitSel), .boostState(boostState),
    .backlightPwmOe(backlightPwmOe), .lowFreqPwmOe(lowFreqPwmOe));
  bbp_load_model bbp_load_model_i (.ref_clk(ref_clk), .reset(reset),
    .powerSwitchOn(powerSwitchOn), .currentLimitSel(currentLimitSel),
    .faultCmd(faultCmd), .slowRamp(slowRamp), .anaFlags(anaFlags));

  // ==========================================================
  // Clock and power-switch activity monitor
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (powerSwitchOn === 1'b1) begin
      runLen = runLen + 1;
      if (runLen > maxRun) maxRun = runLen;
      if (prevPs !== 1'b1) begin
        starts = starts + 1;
        if (prevLed !== 1'b1) badStart = badStart + 1;
      end
    end else runLen = 0;
    prevPs = powerSwitchOn;
    prevLed = ledSwitchOn;
  end

  // ==========================================================
  // Compare, reset and closing tasks
  task automatic chkEq(input logic [31:0] got, input logic [31:0] exp, input string msg);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // Counts from release of reset may skew by a few register stages
  task automatic chkNear(input int got, input int exp, input string msg);
    testsRun++;
    if (got > exp + 4 || got < exp - 4) begin
      badCount++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask

  task automatic wrapUp;
    $display("comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic doReset;
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
  endtask

  task automatic waitState(input bbpBoostState_t s, input int lim);
    int n;
    n = 0;
    while (boostState !== s && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chkEq(32'(boostState), 32'(s), "boost state");
  endtask

  // ==========================================================
  // Expected on-cycles over the first four pulses of a pattern
  function automatic int patHigh(input int n, input int len);
    int c, s;
    logic [7:0] b, r;
    c = (n >= 128) ? 2 * n - 256 : 256 - 2 * n;
    s = 0;
    for (int i = 0; i < 4; i++) begin
      b = 8'(i);
      r = {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
      s += (int'(r) < c) ? ((n >= 128) ? len : 0) : len / 2;
    end
    return s;
  endfunction

  task automatic runPat(input logic [7:0] wd, input logic rs, input logic [7:0] bd,
                        input logic bs);
    int lw, lb, cw, cb;
    lw = rs ? int'(PULSE_FAST_CYC) : int'(PULSE_SLOW_CYC);
    lb = bs ? int'(BKL_HI_CYC) : int'(BKL_LO_CYC);
    cw = 0;
    cb = 0;
    whiteDuty = wd;
    repetitionRateSelect = rs;
    backlightDuty = bd;
    backlightRateSelect = bs;
    doReset;
    for (int k = 0; k < 4 * lb || k < 4 * lw; k++) begin
      @(negedge ref_clk);
      if (k < 4 * lw && ledSwitchOn === 1'b1) cw++;
      if (k < 4 * lb && backlightPwmOe === 1'b1) cb++;
    end
    chkNear(cw, patHigh(wd, lw), "led switch on-time");
    chkNear(cb, patHigh(bd, lb), "backlight on-time");
  endtask

  task automatic runLf(input bbpLfCfg_t c, input int hz);
    int slot, cnt;
    slot = CLK_HZ / (hz * 16);
    cnt = 0;
    lfCfg = c;
    doReset;
    repeat (16 * slot) begin
      @(negedge ref_clk);
      if (lowFreqPwmOe === 1'b1) cnt++;
    end
    chkNear(cnt, c.on ? (int'(c.duty) + 1) * slot : 0, "low-frequency on-time");
  endtask

  // ==========================================================
  // Watchdog and main sequence
  initial begin
    #(95000 * CLK_PERIOD_NS);
    badCount++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrapUp;
  end

  initial begin
    {whiteDuty, backlightDuty, repetitionRateSelect, backlightRateSelect} = '0;
    {lfCfg, faultCmd, slowRamp} = '0;
    {badCount, testsRun, startBase} = '0;
    reset = 1'b1;
    repeat (3) @(negedge ref_clk);
    chkEq({powerSwitchOn, ledSwitchOn, currentLimitSel, boostState, backlightPwmOe,
           lowFreqPwmOe}, 32'h0, "outputs in reset");
    reset = 1'b0;
    repeat (20) @(negedge ref_clk);
    chkEq({powerSwitchOn, ledSwitchOn, boostState}, 32'h0, "idle after reset");
    runPat(8'h00, 1'b1, 8'h00, 1'b1);
    runPat(8'h80, 1'b0, 8'h80, 1'b0);
    runPat(8'hFF, 1'b1, 8'h01, 1'b0);
    runPat(8'hA0, 1'b0, 8'hA0, 1'b1);
    runPat(8'h64, 1'b1, 8'hC8, 1'b0);
    for (int s = 0; s < 8; s++) begin
      runLf('{on: 1'b1, freqSel: 3'(s), duty: 4'(2 * s + 1)}, lfHz[s]);
    end
    runLf('{on: 1'b0, freqSel: 3'h7, duty: 4'hF}, lfHz[7]);
    whiteDuty = 8'hFF;
    doReset;
    waitState(BST_SOFT1, 3);
    startBase = starts;
    waitState(BST_SOFT2, 20000);
    @(negedge ref_clk);
    chkEq(32'(starts - startBase), 32'd256, "first step starts");
    chkEq(currentLimitSel, LIM_250MA, "second limit");
    startBase = starts;
    waitState(BST_RUN, 20000);
    @(negedge ref_clk);
    chkEq(32'(starts - startBase), 32'd256, "second step starts");
    chkEq(currentLimitSel, LIM_500MA, "final limit");
    chkEq(32'(maxRun < int'(MAX_ON_CYC)), 32'd1, "peak trip ends on-time");
    slowRamp = 1'b1;
    repeat (300) @(negedge ref_clk);
    chkEq(32'(maxRun), 32'(MAX_ON_CYC), "max on-time");
    slowRamp = 1'b0;
    faultCmd = 3'h4;
    repeat (5) @(negedge ref_clk);
    startBase = starts;
    repeat (100) @(negedge ref_clk);
    chkEq({powerSwitchOn, 31'(starts - startBase)}, 32'h0, "overvoltage switching");
    faultCmd = 3'h0;
    repeat (100) @(negedge ref_clk);
    chkEq(32'(starts - startBase > 0), 32'd1, "switching resumes");
    for (int f = 0; f < 2; f++) begin
      faultCmd = 3'(1 << f);
      waitState(BST_OFF, 4);
      chkEq({powerSwitchOn, ledSwitchOn}, 32'h0, "switches open on fault");
      faultCmd = 3'h0;
      waitState(BST_SOFT1, 4);
    end
    whiteDuty = 8'h00;
    repeat (2) @(negedge ref_clk);
    startBase = starts;
    repeat (100) @(negedge ref_clk);
    chkEq({powerSwitchOn, ledSwitchOn, boostState, 28'(starts - startBase)}, 32'h0,
          "zero duty");
    chkEq(32'(badStart), 32'h0, "start with led switch open");
    wrapUp;
  end
endmodule // bbp_drivers_bench

// ---- verification/bbp_load_model.sv ----
// Behavioural coil, sense resistor and comparator model beside the boost
`timescale 1ns/1ps
module bbp_load_model
  import bbp_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       powerSwitchOn,
  input  wire logic [1:0] currentLimitSel,
  input  wire logic [2:0] faultCmd,
  input  wire logic       slowRamp,
  output bbpAnaFlags_t    anaFlags
);
  logic [7:0] coil_r;
  logic [3:0] drain_r;
  logic [7:0] tripLevel;

  // ==========================================================
  // Coil ramps while switched, then drains into the output
  assign tripLevel = slowRamp ? 8'hFF : (8'h08 << currentLimitSel);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      coil_r  <= 8'h00;
      drain_r <= 4'h0;
    end else if (powerSwitchOn) begin
      coil_r  <= coil_r + 8'h01;
      drain_r <= 4'h6;
    end else begin
      coil_r  <= 8'h00;
      drain_r <= (drain_r != 4'h0) ? drain_r - 4'h1 : 4'h0;
    end
  end

  // ==========================================================
  // Comparator flags, faults commanded by the bench
  assign anaFlags.overvoltage     = faultCmd[2];
  assign anaFlags.underVoltage    = faultCmd[1];
  assign anaFlags.thermalShutdown = faultCmd[0];
  assign anaFlags.peakCurrentTrip = (coil_r >= tripLevel);
  assign anaFlags.senseBelowRef   = (drain_r == 4'h0);
endmodule // bbp_load_model
